// file: tb/hot_swap_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// board-side switch and rom preload levels
// ****************************************
module hot_swap_host_model (
    input  wire logic i_clk,
    input  wire logic i_busy_cmd,
    input  wire logic i_open_cmd,
    output logic      o_rom_preload_busy,
    output logic      o_ejector_open_state
);
    // registered so both levels change just after an edge, like real board logic
    always_ff @(posedge i_clk) begin
        o_rom_preload_busy   <= i_busy_cmd;
        o_ejector_open_state <= i_open_cmd;
    end
endmodule
`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    typedef struct packed {logic wr; logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_t;
    logic clk = 0;
    logic rst = 1;
    logic busy_cmd = 1;
    logic open_cmd = 0;
    logic [7:0] rdata;
    logic notify, led, busy, eject;
    hot_swap_pkg::cfg_req_t cfg = '0;
    int n_fail = 0;
    int n_checks = 0;
    int cyc = 0;
    row_t rows[7] = '{'{0, 8'h5c, 8'h00, 8'h06}, '{1, 8'h5c, 8'hff, 8'h00}, '{0, 8'h5c, 8'h00, 8'h06},
                      '{0, 8'h5d, 8'h00, 8'h00}, '{0, 8'h40, 8'h00, 8'h00}, '{1, 8'h5e, 8'h3f, 8'h00},
                      '{0, 8'h5e, 8'h00, 8'h8a}};
    always #25 clk = ~clk;
    hot_swap_host_model hot_swap_host_model_inst (.i_clk(clk), .i_busy_cmd(busy_cmd), .i_open_cmd(open_cmd),
        .o_rom_preload_busy(busy), .o_ejector_open_state(eject));
    hot_swap_capability_regs hot_swap_capability_regs_inst (.i_clk(clk), .i_reset(rst), .i_cfg(cfg),
        .i_rom_preload_busy(busy), .i_ejector_open_state(eject), .o_rdata(rdata),
        .o_hot_swap_notify_out(notify), .o_swap_indicator_out(led));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one request cycle; read data is settled at the negedge this returns on
    task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        cfg = {~wr, wr, a, d};
        @(negedge clk);
        cfg = '0;
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 1000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (5) @(negedge clk);
        chk({14'h0000, notify, led}, 16'h0001);
        rst = 0;
        acc(1, 8'h5e, 8'h00);
        repeat (2) @(negedge clk);
        chk({15'h0000, led}, 16'h0001);
        acc(0, 8'h5e, 8'h00);
        chk({8'h00, rdata}, 16'h0000);
        $display("reset and hold done");
        busy_cmd = 0;
        repeat (4) @(negedge clk);
        chk({14'h0000, notify, led}, 16'h0002);
        foreach (rows[i]) begin
            acc(rows[i].wr, rows[i].a, rows[i].d);
            if (!rows[i].wr) begin
                chk({8'h00, rdata}, {8'h00, rows[i].e});
            end
        end
        @(negedge clk);
        chk({14'h0000, notify, led}, 16'h0001);
        $display("table done");
        acc(1, 8'h5e, 8'h80);
        acc(0, 8'h5e, 8'h00);
        chk({8'h00, rdata}, 16'h0000);
        open_cmd = 1;
        repeat (4) @(negedge clk);
        acc(0, 8'h5e, 8'h00);
        chk({7'h00, rdata, notify}, 16'h0081);
        acc(1, 8'h5e, 8'hc0);
        acc(1, 8'h5e, 8'hc0);
        acc(0, 8'h5e, 8'h00);
        chk({8'h00, rdata}, 16'h0000);
        $display("removal done");
        acc(1, 8'h5e, 8'h02);
        open_cmd = 0;
        repeat (2) @(negedge clk);
        open_cmd = 1;
        repeat (4) @(negedge clk);
        acc(0, 8'h5e, 8'h00);
        chk({7'h00, rdata, notify}, 16'h0084);
        $display("masked removal done");
        open_cmd = 0;
        rst = 1;
        repeat (2) @(negedge clk);
        chk({14'h0000, notify, led}, 16'h0001);
        rst = 0;
        repeat (3) @(negedge clk);
        acc(0, 8'h5e, 8'h00);
        chk({7'h00, rdata, notify}, 16'h0101);
        chk({15'h0000, led}, 16'h0000);
        $display("second reset done");
        tally_and_finish();
    end
endmodule
`default_nettype wire

// file: verilog/hot_swap_capability_regs.sv
`timescale 1ns/1ns
`default_nettype none
// Function
// - capability id reads 06h, writes ignored
// - next pointer reads 00h
// - arrival set after reset when ready, no removal
// - removal set on ejector open without arrival
// - software never sets arrival or removal
// - either flag drives notify output
// - mask 0 enables, 1 suppresses; resets 0
// - flags update independent of mask
// - indicator high after reset until ready
// - then indicator follows lamp bit, resets 0
// - reserved bits 5,4,2,0 read zero
module hot_swap_capability_regs (
    input  wire logic                   i_clk,
    input  wire logic                   i_reset,
    input  wire hot_swap_pkg::cfg_req_t i_cfg,
    input  wire logic                   i_rom_preload_busy,
    input  wire logic                   i_ejector_open_state,
    output logic [7:0]                  o_rdata,
    output logic                        o_hot_swap_notify_out,
    output logic                        o_swap_indicator_out
);
    // ****************************************
    // control/status state
    // ****************************************
    logic board_arrival_flag_reg;
    logic removal_pending_flag_reg;
    logic lamp_control_bit_reg;
    logic notify_out_mask_reg;
    logic reset_hold_reg;
    logic arrival_armed_reg;
    logic ejector_prev_reg;
    logic ready;
    logic csr_wr;
    logic arrival_set;
    logic removal_set;

    assign ready  = !i_rom_preload_busy && !i_ejector_open_state;
    assign csr_wr = i_cfg.wr && i_cfg.addr == hot_swap_pkg::CSR_OFFSET;
    // arrival is reported once per bus reset, not every time the ejector closes
    assign arrival_set = arrival_armed_reg && ready && !removal_pending_flag_reg;
    assign removal_set = i_ejector_open_state && !ejector_prev_reg && !board_arrival_flag_reg;

    // the edge detector resets to the closed level, so an ejector already open through reset counts as an opening
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            arrival_armed_reg <= 1'b1;
            ejector_prev_reg  <= 1'b0;
        end else begin
            ejector_prev_reg <= i_ejector_open_state;
            if (arrival_set) begin
                arrival_armed_reg <= 1'b0;
            end
        end
    end

    // set wins over a write-one clear; writes can only clear
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            board_arrival_flag_reg <= 1'b0;
        end else if (arrival_set) begin
            board_arrival_flag_reg <= 1'b1;
        end else if (csr_wr && i_cfg.wdata[hot_swap_pkg::ARRIVAL_BIT]) begin
            board_arrival_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            removal_pending_flag_reg <= 1'b0;
        end else if (removal_set) begin
            removal_pending_flag_reg <= 1'b1;
        end else if (csr_wr && i_cfg.wdata[hot_swap_pkg::REMOVAL_BIT]) begin
            removal_pending_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            lamp_control_bit_reg <= 1'b0;
            notify_out_mask_reg  <= 1'b0;
        end else if (csr_wr) begin
            lamp_control_bit_reg <= i_cfg.wdata[hot_swap_pkg::LAMP_BIT];
            notify_out_mask_reg  <= i_cfg.wdata[hot_swap_pkg::MASK_BIT];
        end
    end

    // a slow preload keeps the lamp lit, the cue that the board is not yet usable
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            reset_hold_reg <= 1'b1;
        end else if (ready) begin
            reset_hold_reg <= 1'b0;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_hot_swap_notify_out <= 1'b0;
            o_swap_indicator_out  <= 1'b1;
        end else begin
            o_hot_swap_notify_out <= (board_arrival_flag_reg || removal_pending_flag_reg)
                                     && !notify_out_mask_reg;
            o_swap_indicator_out  <= reset_hold_reg ? 1'b1 : lamp_control_bit_reg;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_rdata <= 8'h00;
        end else if (i_cfg.rd) begin
            unique case (i_cfg.addr)
                hot_swap_pkg::CAP_ID_OFFSET:   o_rdata <= hot_swap_pkg::CAP_ID_VALUE;
                hot_swap_pkg::NEXT_PTR_OFFSET: o_rdata <= hot_swap_pkg::NEXT_PTR_VALUE;
                hot_swap_pkg::CSR_OFFSET:      o_rdata <= {board_arrival_flag_reg, removal_pending_flag_reg,
                                                           2'b00, lamp_control_bit_reg, 1'b0,
                                                           notify_out_mask_reg, 1'b0};
                default:                       o_rdata <= 8'h00;
            endcase
        end
    end

    // ****************************************
    // checks
    // ****************************************
    a_cap_id_read: assert property (@(posedge i_clk) disable iff (i_reset)
        i_cfg.rd && i_cfg.addr == hot_swap_pkg::CAP_ID_OFFSET |=> o_rdata == 8'h06)
        else $error("capability id wrong");
    a_next_ptr_read: assert property (@(posedge i_clk) disable iff (i_reset)
        i_cfg.rd && i_cfg.addr == hot_swap_pkg::NEXT_PTR_OFFSET |=> o_rdata == 8'h00)
        else $error("next pointer wrong");
    a_reserved_zero: assert property (@(posedge i_clk) disable iff (i_reset)
        i_cfg.rd && i_cfg.addr == hot_swap_pkg::CSR_OFFSET |=> (o_rdata & 8'h35) == 8'h00)
        else $error("reserved bits not zero");
    a_arrival_sets: assert property (@(posedge i_clk) disable iff (i_reset)
        arrival_set |=> board_arrival_flag_reg)
        else $error("arrival not set");
    a_removal_sets: assert property (@(posedge i_clk) disable iff (i_reset)
        i_ejector_open_state && !$past(i_ejector_open_state) && !board_arrival_flag_reg |=> removal_pending_flag_reg)
        else $error("removal not set");
    a_no_sw_set: assert property (@(posedge i_clk) disable iff (i_reset)
        $rose(board_arrival_flag_reg) |-> $past(arrival_set))
        else $error("arrival set without cause");
    a_notify_drive: assert property (@(posedge i_clk) disable iff (i_reset)
        (board_arrival_flag_reg || removal_pending_flag_reg) && !notify_out_mask_reg |=> o_hot_swap_notify_out)
        else $error("notify not driven");
    a_mask_blocks: assert property (@(posedge i_clk) disable iff (i_reset)
        notify_out_mask_reg |=> !o_hot_swap_notify_out)
        else $error("mask ignored");
    a_indicator_hold: assert property (@(posedge i_clk) disable iff (i_reset)
        reset_hold_reg |=> o_swap_indicator_out)
        else $error("indicator not held high");
    a_indicator_lamp: assert property (@(posedge i_clk) disable iff (i_reset)
        !reset_hold_reg |=> o_swap_indicator_out == $past(lamp_control_bit_reg))
        else $error("indicator not following lamp");
    a_clear_one: assert property (@(posedge i_clk) disable iff (i_reset)
        csr_wr && i_cfg.wdata[7] && !arrival_set |=> !board_arrival_flag_reg)
        else $error("arrival not cleared");

    // ****************************************
    // flag checks
    // ****************************************
    // each flag moves only through its own set term or a write-one clear
    a_set_wins_arrival: assert property (@(posedge i_clk) disable iff (i_reset)
        arrival_set && csr_wr && i_cfg.wdata[hot_swap_pkg::ARRIVAL_BIT] |=> board_arrival_flag_reg)
        else $error("arrival lost to clear");

    a_set_wins_removal: assert property (@(posedge i_clk) disable iff (i_reset)
        removal_set && csr_wr && i_cfg.wdata[hot_swap_pkg::REMOVAL_BIT] |=> removal_pending_flag_reg)
        else $error("removal lost to clear");

    a_arrival_ready: assert property (@(posedge i_clk) disable iff (i_reset)
        $rose(board_arrival_flag_reg) |-> $past(!i_rom_preload_busy && !i_ejector_open_state
                                               && !removal_pending_flag_reg))
        else $error("arrival set while not ready");

    a_arrival_once: assert property (@(posedge i_clk) disable iff (i_reset)
        !arrival_armed_reg && !board_arrival_flag_reg |=> !board_arrival_flag_reg)
        else $error("arrival set twice");

    a_removal_edge: assert property (@(posedge i_clk) disable iff (i_reset)
        $rose(removal_pending_flag_reg) |-> $past(i_ejector_open_state && !board_arrival_flag_reg))
        else $error("removal set without opening");

    a_no_sw_removal: assert property (@(posedge i_clk) disable iff (i_reset)
        $rose(removal_pending_flag_reg) |-> $past(removal_set))
        else $error("removal set without cause");

    a_arrival_steady: assert property (@(posedge i_clk) disable iff (i_reset)
        !arrival_set && !(csr_wr && i_cfg.wdata[hot_swap_pkg::ARRIVAL_BIT])
        |=> board_arrival_flag_reg == $past(board_arrival_flag_reg))
        else $error("arrival moved by itself");

    a_removal_steady: assert property (@(posedge i_clk) disable iff (i_reset)
        !removal_set && !(csr_wr && i_cfg.wdata[hot_swap_pkg::REMOVAL_BIT])
        |=> removal_pending_flag_reg == $past(removal_pending_flag_reg))
        else $error("removal moved by itself");

    a_removal_clear: assert property (@(posedge i_clk) disable iff (i_reset)
        csr_wr && i_cfg.wdata[hot_swap_pkg::REMOVAL_BIT] && !removal_set |=> !removal_pending_flag_reg)
        else $error("removal not cleared");

    a_sets_exclusive: assert property (@(posedge i_clk) disable iff (i_reset)
        removal_set |-> !arrival_set)
        else $error("arrival and removal set together");

    // the mask only gates the pin, so events must still land with it set
    a_mask_arrival: assert property (@(posedge i_clk) disable iff (i_reset)
        notify_out_mask_reg && arrival_set |=> board_arrival_flag_reg)
        else $error("masked arrival lost");

    a_mask_removal: assert property (@(posedge i_clk) disable iff (i_reset)
        notify_out_mask_reg && removal_set |=> removal_pending_flag_reg)
        else $error("masked removal lost");

    // ****************************************
    // control checks
    // ****************************************
    // writes elsewhere in the capability must leave the control bits alone
    a_mask_write: assert property (@(posedge i_clk) disable iff (i_reset)
        csr_wr |=> notify_out_mask_reg == $past(i_cfg.wdata[hot_swap_pkg::MASK_BIT]))
        else $error("mask not written");

    a_lamp_write: assert property (@(posedge i_clk) disable iff (i_reset)
        csr_wr |=> lamp_control_bit_reg == $past(i_cfg.wdata[hot_swap_pkg::LAMP_BIT]))
        else $error("lamp not written");

    a_other_wr_ignored: assert property (@(posedge i_clk) disable iff (i_reset)
        i_cfg.wr && i_cfg.addr != hot_swap_pkg::CSR_OFFSET
        |=> $stable(lamp_control_bit_reg) && $stable(notify_out_mask_reg))
        else $error("stray write landed");

    // ****************************************
    // output checks
    // ****************************************
    a_notify_cause: assert property (@(posedge i_clk) disable iff (i_reset)
        o_hot_swap_notify_out |-> $past(board_arrival_flag_reg || removal_pending_flag_reg))
        else $error("notify without flag");

    a_notify_unmasked: assert property (@(posedge i_clk) disable iff (i_reset)
        o_hot_swap_notify_out |-> !$past(notify_out_mask_reg))
        else $error("notify while masked");

    a_notify_idle: assert property (@(posedge i_clk) disable iff (i_reset)
        !board_arrival_flag_reg && !removal_pending_flag_reg |=> !o_hot_swap_notify_out)
        else $error("notify with no flag");

    // the hold is one-way; only a second bus reset brings it back
    a_hold_release: assert property (@(posedge i_clk) disable iff (i_reset)
        reset_hold_reg && ready |=> !reset_hold_reg)
        else $error("hold not released");

    a_hold_wait: assert property (@(posedge i_clk) disable iff (i_reset)
        reset_hold_reg && !ready |=> reset_hold_reg)
        else $error("hold released early");

    a_hold_gone: assert property (@(posedge i_clk) disable iff (i_reset)
        !reset_hold_reg |=> !reset_hold_reg)
        else $error("hold came back");

    a_indicator_low: assert property (@(posedge i_clk) disable iff (i_reset)
        !o_swap_indicator_out |-> !$past(reset_hold_reg) && !$past(lamp_control_bit_reg))
        else $error("indicator low without cause");

    // ****************************************
    // read checks
    // ****************************************
    // read data stands between reads, so a host may take it late
    a_unmapped_zero: assert property (@(posedge i_clk) disable iff (i_reset)
        i_cfg.rd && i_cfg.addr != hot_swap_pkg::CAP_ID_OFFSET && i_cfg.addr != hot_swap_pkg::NEXT_PTR_OFFSET
        && i_cfg.addr != hot_swap_pkg::CSR_OFFSET |=> o_rdata == 8'h00)
        else $error("unmapped read not zero");

    a_rdata_stands: assert property (@(posedge i_clk) disable iff (i_reset)
        !i_cfg.rd |=> $stable(o_rdata))
        else $error("read data moved");

    a_csr_flags_read: assert property (@(posedge i_clk) disable iff (i_reset)
        i_cfg.rd && i_cfg.addr == hot_swap_pkg::CSR_OFFSET
        |=> o_rdata[hot_swap_pkg::ARRIVAL_BIT] == $past(board_arrival_flag_reg)
            && o_rdata[hot_swap_pkg::REMOVAL_BIT] == $past(removal_pending_flag_reg))
        else $error("flags read wrong");

    a_lamp_read: assert property (@(posedge i_clk) disable iff (i_reset)
        i_cfg.rd && i_cfg.addr == hot_swap_pkg::CSR_OFFSET
        |=> o_rdata[hot_swap_pkg::LAMP_BIT] == $past(lamp_control_bit_reg))
        else $error("lamp read wrong");

    a_mask_read: assert property (@(posedge i_clk) disable iff (i_reset)
        i_cfg.rd && i_cfg.addr == hot_swap_pkg::CSR_OFFSET
        |=> o_rdata[hot_swap_pkg::MASK_BIT] == $past(notify_out_mask_reg))
        else $error("mask read wrong");

    a_cap_after_write: assert property (@(posedge i_clk) disable iff (i_reset)
        i_cfg.wr && i_cfg.addr == hot_swap_pkg::CAP_ID_OFFSET
        ##1 i_cfg.rd && i_cfg.addr == hot_swap_pkg::CAP_ID_OFFSET
        |=> o_rdata == hot_swap_pkg::CAP_ID_VALUE)
        else $error("capability id took a write");

    a_next_after_write: assert property (@(posedge i_clk) disable iff (i_reset)
        i_cfg.wr && i_cfg.addr == hot_swap_pkg::NEXT_PTR_OFFSET
        ##1 i_cfg.rd && i_cfg.addr == hot_swap_pkg::NEXT_PTR_OFFSET
        |=> o_rdata == hot_swap_pkg::NEXT_PTR_VALUE)
        else $error("next pointer took a write");

    c_arrival:  cover property (@(posedge i_clk) disable iff (i_reset) $rose(board_arrival_flag_reg));
    c_removal:  cover property (@(posedge i_clk) disable iff (i_reset) $rose(removal_pending_flag_reg));
    c_masked:   cover property (@(posedge i_clk) disable iff (i_reset)
        board_arrival_flag_reg && notify_out_mask_reg);
    c_lamp_off: cover property (@(posedge i_clk) disable iff (i_reset) $fell(o_swap_indicator_out));
    c_hold_end: cover property (@(posedge i_clk) disable iff (i_reset) $fell(reset_hold_reg));
endmodule
`default_nettype wire

// file: verilog/hot_swap_pkg.sv
`default_nettype none
package hot_swap_pkg;
    // byte addresses in configuration space
    localparam logic [7:0] CAP_ID_OFFSET   = 8'h5c;
    localparam logic [7:0] NEXT_PTR_OFFSET = 8'h5d;
    localparam logic [7:0] CSR_OFFSET      = 8'h5e;
    localparam logic [7:0] CAP_ID_VALUE    = 8'h06;
    localparam logic [7:0] NEXT_PTR_VALUE  = 8'h00;
    localparam logic [7:0] CSR_RESET       = 8'h00;
    // field positions in the control/status byte
    localparam int ARRIVAL_BIT = 7;
    localparam int REMOVAL_BIT = 6;
    localparam int LAMP_BIT    = 3;
    localparam int MASK_BIT    = 1;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cfg_req_t;
endpackage
`default_nettype wire
